// File: hw/wdt_sleep_defines.svh
// constants for the watchdog and sleep/wake block
// assumes byte addresses on a 32-bit Avalon-MM register bus
`ifndef WDT_SLEEP_DEFINES_SVH
`define WDT_SLEEP_DEFINES_SVH

// register byte offsets
`define OFF_CONFIG      4'h0
`define OFF_RESET_CAUSE 4'h4
`define OFF_SW_CONTROL  4'h8

// watchdog_config_byte fields
`define CFG_ENABLE_BIT  0
`define CFG_RATIO_LSB   1
`define CFG_RATIO_MSB   3

// reset_cause_control fields
`define RC_PD_BIT       3
`define RC_TO_BIT       4

// watchdog_software_control fields
`define SW_ENABLE_BIT   0
`define SW_CONTROL_RST  8'h00

// oscillator start-up: time in oscillator periods
`define CLK_PERIOD_NS   20
`define OST_OSC_PERIODS 1024
`define OST_TIME_NS     (`OST_OSC_PERIODS * `CLK_PERIOD_NS)
`define OST_CYCLES      (`OST_TIME_NS / `CLK_PERIOD_NS)

// default base watchdog period in watchdog oscillator ticks
`define WDT_BASE_TICKS  16'h0400

`endif

// File: hw/wdt_sleep_pkg.sv
// types shared by the watchdog and sleep/wake block
// assumes nothing beyond the defines header
package wdt_sleep_pkg;

  typedef enum logic [1:0] {
    ST_RUN,
    ST_SLEEP,
    ST_OSC_WAIT
  } state_type;

  // instruction events from the core
  typedef struct packed {
    logic        clrWdtInstr;
    logic        sleepInstr;
    logic        globalIntEnable;
    logic [20:0] pc;
  } core_req_type;

  // answers to the core
  typedef struct packed {
    logic        deviceReset;
    logic        resume;
    logic        branchToVector;
    logic [20:0] prefetchAddr;
  } core_ctl_type;

endpackage

// File: hw/wdt_sleep_ctrl.sv
// watchdog timer and power-down (sleep) control
// assumes a core that pulses clear-watchdog and sleep events for one
// cycle, a watchdog RC oscillator seen as a one-cycle tick, and an
// Avalon-MM master with waitrequest
// the watchdog oscillator tick is taken as already synchronous to
// core_clk; a free-running RC source needs a synchroniser and an
// edge detector in front of this block
// cfgByte is programmed once and treated as static while running
`timescale 1ns/10ps
`default_nettype none
`include "wdt_sleep_defines.svh"

module wdt_sleep_ctrl
  import wdt_sleep_pkg::*;
#(
  parameter logic [15:0] WDT_BASE_TICKS = `WDT_BASE_TICKS,
  parameter int          NUM_WAKE       = 13
) (
  input  wire logic                core_clk,
  input  wire logic                arst_n,
  input  wire logic [3:0]          avsAddress,
  input  wire logic                avsRead,
  input  wire logic                avsWrite,
  input  wire logic [31:0]         avsWriteData,
  input  wire logic [3:0]          avsByteEnable,
  output logic [31:0]              avsReadData,
  output logic                     avsWaitrequest,
  input  wire logic                wdtOscTick,
  input  wire logic [7:0]          cfgByte,
  input  wire logic                masterResetReq,
  input  wire logic                oscCrystalMode,
  input  wire core_req_type        coreReq,
  input  wire logic [NUM_WAKE-1:0] wakeFlags,
  input  wire logic [NUM_WAKE-1:0] wakeEnables,
  input  wire logic                clockedIntPending,
  output core_ctl_type             coreCtl,
  output logic                     mainOscEnable,
  output logic                     ioHold,
  output logic                     sleeping
);

  // power state
  state_type    state_r;
  state_type    state_nxt;

  // watchdog base count and postscaler count
  logic [15:0]  baseCnt_r;
  logic [15:0]  baseCnt_nxt;
  logic [6:0]   postCnt_r;
  logic [6:0]   postCnt_nxt;

  // oscillator start-up count
  logic [10:0]  ostCnt_r;

  // status, control and wake cause
  logic         swEnable_r;
  logic         timeoutN_r;
  logic         powerdownN_r;
  logic         wakeByInt_r;

  // register bus
  logic         ack_r;
  logic [31:0]  readData_r;

  // registered outputs to the core and the pins
  core_ctl_type coreCtl_r;
  logic         oscOn_r;
  logic         ioHold_r;

  // wake sources, one per clockless interrupt
  wire [NUM_WAKE-1:0] wakeHit;

  genvar gi;
  generate
    for (gi = 0; gi < NUM_WAKE; gi++) begin : g_wake
      assign wakeHit[gi] = wakeFlags[gi] & wakeEnables[gi];
    end
  endgenerate

  // global enable does not gate the wake path
  wire anyWake    = |wakeHit;
  wire anyPending = anyWake | clockedIntPending;

  // watchdog enable and postscaler selection; software cannot stop a
  // watchdog that the config byte forces on
  wire       cfgEnable = cfgByte[`CFG_ENABLE_BIT];
  wire [2:0] ratioSel  = cfgByte[`CFG_RATIO_MSB:`CFG_RATIO_LSB];
  wire       wdtRun    = cfgEnable | swEnable_r;

  // ratio 1:2^sel; the encoding is a choice of this block
  // 1:1 up to 1:128, so the last postscaler count fits seven bits
  wire [7:0] postDiv  = 8'h01 << ratioSel;
  wire [6:0] postLast = 7'(postDiv - 8'h01);

  // last values of both counts; the ratio is static, so no register
  wire baseLast = (baseCnt_r == 16'(WDT_BASE_TICKS - 16'h0001));
  wire postDone = (postCnt_r == postLast);

  // counts only on watchdog oscillator ticks, so it runs in sleep
  wire wdtStep  = wdtRun & wdtOscTick;
  wire expiry   = wdtStep & baseLast & postDone;

  // state decode
  wire inRun   = (state_r == ST_RUN);
  wire inSleep = (state_r == ST_SLEEP);
  wire inOsc   = (state_r == ST_OSC_WAIT);

  // sleep is a no-op when an enabled interrupt already waits; an expiry
  // or external reset in the same cycle wins, so no flag is touched by
  // a sleep that never happened
  wire sleepTaken = inRun & coreReq.sleepInstr & ~anyPending
                    & ~expiry & ~masterResetReq;
  wire clrTaken   = inRun & coreReq.clrWdtInstr;

  // any expiry outside sleep is a device reset, the start-up wait too
  wire wdtReset  = expiry & ~inSleep & ~masterResetReq;
  // an interrupt that comes after sleep was taken wakes at once
  wire wakeEvent = inSleep & ~masterResetReq
                   & (expiry | anyWake);
  // the start-up count runs from 0 to one below the delay
  wire ostDone   = inOsc & (ostCnt_r == 11'(`OST_CYCLES - 1));

  // resume straight away unless a crystal must restart
  // the start-up count needs the restarted main clock, hence a state
  wire wakeDone  = (wakeEvent & ~oscCrystalMode)
                   | (ostDone & ~masterResetReq);

  // counter clear leaves the ratio select untouched
  wire wdtClear  = clrTaken | sleepTaken | expiry;

  // watchdog counters
  // a clear beats a tick in the same cycle, so no count slips past it
  always_comb begin
    baseCnt_nxt = baseCnt_r;
    postCnt_nxt = postCnt_r;
    if (wdtClear) begin
      baseCnt_nxt = 16'h0000;
      postCnt_nxt = 7'h00;
    end else if (wdtStep) begin
      if (baseLast) begin
        baseCnt_nxt = 16'h0000;
        postCnt_nxt = 7'(postCnt_r + 7'h01);
      end else begin
        baseCnt_nxt = 16'(baseCnt_r + 16'h0001);
      end
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      baseCnt_r <= 16'h0000;
      postCnt_r <= 7'h00;
    end else begin
      baseCnt_r <= baseCnt_nxt;
      postCnt_r <= postCnt_nxt;
    end
  end

  // power state sequence
  // external reset ends sleep and the start-up wait at once
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ST_RUN: begin
        if (sleepTaken) begin
          state_nxt = ST_SLEEP;
        end
      end
      ST_SLEEP: begin
        if (masterResetReq) begin
          state_nxt = ST_RUN;
        end else if (wakeEvent) begin
          state_nxt = oscCrystalMode ? ST_OSC_WAIT : ST_RUN;
        end
      end
      ST_OSC_WAIT: begin
        if (masterResetReq | ostDone) begin
          state_nxt = ST_RUN;
        end
      end
      default: begin
        state_nxt = ST_RUN;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_r <= ST_RUN;
    end else begin
      state_r <= state_nxt;
    end
  end

  // start-up delay, counted on the restarted main clock
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      ostCnt_r <= 11'h000;
    end else if (inOsc) begin
      ostCnt_r <= 11'(ostCnt_r + 11'h001);
    end else begin
      ostCnt_r <= 11'h000;
    end
  end

  // remember why sleep ended, for the vector branch
  // an expiry together with an interrupt counts as a watchdog wake
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      wakeByInt_r <= 1'b0;
    end else if (wakeEvent) begin
      wakeByInt_r <= anyWake & ~expiry;
    end
  end

  // status flags; power-up is the async reset
  // expiry beats sleep; sleepTaken already excludes that cycle
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      timeoutN_r   <= 1'b1;
      powerdownN_r <= 1'b1;
    end else begin
      if (expiry) begin
        timeoutN_r <= 1'b0;
      end else if (sleepTaken) begin
        timeoutN_r <= 1'b1;
      end
      if (sleepTaken) begin
        powerdownN_r <= 1'b0;
      end
    end
  end

  // pin hold and oscillator driver follow the next state
  // so that pins, oscillator and state move together; one flop each,
  // but no glitch reaches the pins
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      oscOn_r  <= 1'b1;
      ioHold_r <= 1'b0;
    end else begin
      oscOn_r  <= (state_nxt != ST_SLEEP);
      ioHold_r <= (state_nxt != ST_RUN);
    end
  end

  // sleeping mirrors the oscillator driver, so one flop serves both
  assign mainOscEnable = oscOn_r;
  assign ioHold        = ioHold_r;
  assign sleeping      = ~oscOn_r;

  // cause as seen in the cycle that resumes
  wire wakeByIntNow = inSleep ? (anyWake & ~expiry) : wakeByInt_r;

  // core answers, all registered pulses except the address; the
  // prefetch address is a level that stands until the next sleep
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      coreCtl_r <= '0;
    end else begin
      coreCtl_r.deviceReset    <= wdtReset | masterResetReq;
      coreCtl_r.resume         <= wakeDone;
      coreCtl_r.branchToVector <= wakeDone & wakeByIntNow
                                  & coreReq.globalIntEnable;
      if (coreReq.sleepInstr) begin
        coreCtl_r.prefetchAddr <= 21'(coreReq.pc + 21'h00_0002);
      end
    end
  end

  assign coreCtl = coreCtl_r;

  // register bus: one wait cycle, answer on the second; ack toggles,
  // so back-to-back requests each see exactly one wait cycle
  wire busReq  = avsRead | avsWrite;
  wire busDone = busReq & ack_r;
  wire hitCfg  = (avsAddress == `OFF_CONFIG);
  wire hitRc   = (avsAddress == `OFF_RESET_CAUSE);
  wire hitSw   = (avsAddress == `OFF_SW_CONTROL);
  wire swWrite = avsWrite & busDone & hitSw & avsByteEnable[0];

  assign avsWaitrequest = busReq & ~ack_r;

  // unused bits and unmapped words read as zero
  // reset cause word: timeout flag at bit 4, powerdown flag at bit 3
  wire [31:0] cfgWord = {28'h000_0000, cfgByte[3:0]};
  wire [31:0] rcWord  = {27'h000_0000, timeoutN_r,
                         powerdownN_r, 3'h0};
  wire [31:0] swWord  = {31'h0000_0000, swEnable_r};
  wire [31:0] rdMux   = hitCfg ? cfgWord :
                        hitRc  ? rcWord  :
                        hitSw  ? swWord  : 32'h0000_0000;

  // read data captured in the wait cycle, held until the next read
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      ack_r      <= 1'b0;
      readData_r <= 32'h0000_0000;
    end else begin
      ack_r <= busReq & ~ack_r;
      if (avsRead & ~ack_r) begin
        readData_r <= rdMux;
      end
    end
  end

  assign avsReadData = readData_r;

  // software enable; only bit 0 is writable
  // a write with lane 0 off changes nothing
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      swEnable_r <= 1'(`SW_CONTROL_RST);
    end else if (swWrite) begin
      swEnable_r <= avsWriteData[`SW_ENABLE_BIT];
    end
  end

endmodule

`default_nettype wire

// File: tb/wdt_sleep_ctrl_checker.sv
// assertions on the watchdog and sleep/wake ports
// assumes it is bound to every wdt_sleep_ctrl instance
`timescale 1ns/10ps
`default_nettype none
module wdt_sleep_ctrl_checker
  import wdt_sleep_pkg::*;
#(
  parameter int NUM_WAKE = 13
) (
  input wire logic                core_clk,
  input wire logic                arst_n,
  input wire logic [3:0]          avsAddress,
  input wire logic                avsRead,
  input wire logic                avsWaitrequest,
  input wire logic [31:0]         avsReadData,
  input wire logic                masterResetReq,
  input wire logic                oscCrystalMode,
  input wire core_req_type        coreReq,
  input wire logic [NUM_WAKE-1:0] wakeFlags,
  input wire logic [NUM_WAKE-1:0] wakeEnables,
  input wire logic                clockedIntPending,
  input wire core_ctl_type        coreCtl,
  input wire logic                mainOscEnable,
  input wire logic                ioHold,
  input wire logic                sleeping
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  // an enabled clockless source is asking to wake
  wire hit = |(wakeFlags & wakeEnables);

  osc_off_a: assert property ($rose(sleeping) |-> $past(coreReq.sleepInstr)) else $error("osc");
  pins_held_a: assert property (sleeping |-> ioHold) else $error("hold");
  sleep_noop_a: assert property (coreReq.sleepInstr && !sleeping && clockedIntPending
    |=> !sleeping) else $error("noop");
  prefetch_next_a: assert property (coreReq.sleepInstr && !sleeping
    |=> coreCtl.prefetchAddr == $past(coreReq.pc) + 21'h2) else $error("pc");
  int_wake_a: assert property (sleeping && hit && !oscCrystalMode && !masterResetReq
    |=> coreCtl.resume) else $error("wake");
  ext_reset_a: assert property (masterResetReq |=> coreCtl.deviceReset) else $error("rst");
  vector_after_a: assert property (coreCtl.branchToVector |-> coreCtl.resume) else $error("vec");
  osc_delay_a: assert property (sleeping && hit && oscCrystalMode && !masterResetReq
    |=> !coreCtl.resume [*8]) else $error("ost");
  sw_upper_a: assert property (avsRead && !avsWaitrequest && avsAddress == 4'h8
    |=> avsReadData[31:1] == 31'h0) else $error("upper");
endmodule
bind wdt_sleep_ctrl wdt_sleep_ctrl_checker #(
  .NUM_WAKE(NUM_WAKE)
) chk (
  .core_clk          (core_clk),
  .arst_n            (arst_n),
  .avsAddress        (avsAddress),
  .avsRead           (avsRead),
  .avsWaitrequest    (avsWaitrequest),
  .avsReadData       (avsReadData),
  .masterResetReq    (masterResetReq),
  .oscCrystalMode    (oscCrystalMode),
  .coreReq           (coreReq),
  .wakeFlags         (wakeFlags),
  .wakeEnables       (wakeEnables),
  .clockedIntPending (clockedIntPending),
  .coreCtl           (coreCtl),
  .mainOscEnable     (mainOscEnable),
  .ioHold            (ioHold),
  .sleeping          (sleeping)
);
`default_nettype wire

// File: tb/core_model.sv
// processor core model: issues clear and sleep instructions
// assumes the block answers with one-cycle pulses on coreCtl
`timescale 1ns/10ps
`default_nettype none
module core_model
  import wdt_sleep_pkg::*;
(
  input  wire logic   core_clk,
  input  wire logic   arst_n,
  input  wire core_ctl_type coreCtl,
  output core_req_type coreReq,
  output int          resets
);
  initial coreReq = '0;
  // count device resets asked of the core
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) resets <= 0;
    else resets <= resets + int'(coreCtl.deviceReset);
  end
  // one instruction pulse; pc steps a word at a time
  task automatic issue(input logic slp, input logic g);
    @(posedge core_clk);
    coreReq.sleepInstr <= slp;
    coreReq.clrWdtInstr <= !slp;
    coreReq.globalIntEnable <= g;
    coreReq.pc <= coreReq.pc + 21'h2;
    @(posedge core_clk);
    coreReq.sleepInstr <= 1'b0;
    coreReq.clrWdtInstr <= 1'b0;
  endtask
endmodule
`default_nettype wire

// File: tb/tb.sv
// self-checking bench for the watchdog and sleep/wake block
// assumes the core model and the bound checker are compiled first
`timescale 1ns/10ps
`default_nettype none
module tb;
  import wdt_sleep_pkg::*;
  logic         core_clk = 0, arst_n = 0, avsRead = 0, avsWrite = 0;
  logic [3:0]   avsAddress = '0, avsByteEnable = 4'hf;
  logic [31:0]  avsWriteData = '0, avsReadData, q;
  logic         wdtOscTick = 0, tickOn = 0, masterResetReq = 0, oscCrystalMode = 0;
  logic         clockedIntPending = 0, avsWaitrequest, mainOscEnable, ioHold, sleeping;
  logic [12:0]  wakeFlags = '0, wakeEnables = '0;
  logic [1:0]   tickDiv = '0;
  logic [7:0]   cfgByte = 8'h02;
  core_req_type coreReq;
  core_ctl_type coreCtl;
  int           numErrors = 0, comparisons = 0, n, rst0, resets;

  // base period 4 ticks, ratio select 1 gives 2
  wdt_sleep_ctrl #(
    .WDT_BASE_TICKS(16'h0004)
  ) uut (
    .core_clk          (core_clk),
    .arst_n            (arst_n),
    .avsAddress        (avsAddress),
    .avsRead           (avsRead),
    .avsWrite          (avsWrite),
    .avsWriteData      (avsWriteData),
    .avsByteEnable     (avsByteEnable),
    .avsReadData       (avsReadData),
    .avsWaitrequest    (avsWaitrequest),
    .wdtOscTick        (wdtOscTick),
    .cfgByte           (cfgByte),
    .masterResetReq    (masterResetReq),
    .oscCrystalMode    (oscCrystalMode),
    .coreReq           (coreReq),
    .wakeFlags         (wakeFlags),
    .wakeEnables       (wakeEnables),
    .clockedIntPending (clockedIntPending),
    .coreCtl           (coreCtl),
    .mainOscEnable     (mainOscEnable),
    .ioHold            (ioHold),
    .sleeping          (sleeping)
  );
  core_model core (
    .core_clk (core_clk),
    .arst_n   (arst_n),
    .coreCtl  (coreCtl),
    .coreReq  (coreReq),
    .resets   (resets)
  );

  initial forever #10 core_clk = ~core_clk;
  // watchdog oscillator tick every fourth cycle, only when asked
  always @(posedge core_clk) begin
    tickDiv <= tickDiv + 2'h1;
    wdtOscTick <= tickOn && tickDiv == 2'h0;
  end

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      numErrors++;
      $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // avalon access: held until waitrequest is sampled low at a rising
  // edge; read data taken and request dropped at that same edge
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge core_clk);
    avsRead <= !w;
    avsWrite <= w;
    avsAddress <= a;
    avsWriteData <= d;
    do @(posedge core_clk); while (avsWaitrequest !== 1'b0);
    q = avsReadData;
    avsRead <= 1'b0;
    avsWrite <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    bus(1'b0, a, '0);
    chk(q, e);
  endtask
  // wait for resume or reset at rising edges; leaves n cycles taken
  task automatic waitPulse;
    n = 0;
    do begin @(posedge core_clk); n++; end
    while (!(coreCtl.resume || coreCtl.deviceReset));
  endtask
  function automatic logic [31:0] pulses;
    return {29'h0, coreCtl.resume, coreCtl.branchToVector, coreCtl.deviceReset};
  endfunction
  task automatic setTick(input logic v);
    @(posedge core_clk);
    tickOn <= v;
  endtask
  task automatic give_verdict;
    $display("compares %0d errors %0d", comparisons, numErrors);
    if (numErrors == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic t_regs;
    rd(4'h0, 32'h0000_0002);
    rd(4'h4, 32'h0000_0018);
    rd(4'h8, 32'h0000_0000);
    rd(4'hc, 32'h0000_0000);
    bus(1'b1, 4'h4, 32'h0000_0000);
    bus(1'b1, 4'h8, 32'hffff_ffff);
    rd(4'h8, 32'h0000_0001);
    rd(4'h4, 32'h0000_0018);
    $display("regs done");
  endtask
  task automatic t_enable;
    bus(1'b1, 4'h8, 32'h0000_0000);
    rd(4'h8, 32'h0000_0000);
    rst0 = resets;
    setTick(1'b1);
    repeat (60) @(posedge core_clk);
    chk(resets, rst0);
    cfgByte <= 8'h03;
    bus(1'b1, 4'h8, 32'h0000_0000);
    waitPulse;
    chk(pulses(), 32'h0000_0001);
    rd(4'h0, 32'h0000_0003);
    setTick(1'b0);
    cfgByte <= 8'h02;
    avsByteEnable <= 4'he;
    bus(1'b1, 4'h8, 32'hffff_ffff);
    avsByteEnable <= 4'hf;
    rd(4'h8, 32'h0000_0000);
    bus(1'b1, 4'h8, 32'h0000_0001);
    $display("enable done");
  endtask
  task automatic t_expire;
    setTick(1'b1);
    waitPulse;
    chk(pulses(), 32'h0000_0001);
    setTick(1'b0);
    rd(4'h4, 32'h0000_0008);
    $display("expire done");
  endtask
  task automatic t_clear;
    rst0 = resets;
    setTick(1'b1);
    repeat (15) begin
      core.issue(1'b0, 1'b0);
      repeat (4) @(posedge core_clk);
    end
    setTick(1'b0);
    chk(resets, rst0);
    $display("clear done");
  endtask
  task automatic t_noop;
    @(posedge core_clk);
    clockedIntPending <= 1'b1;
    core.issue(1'b1, 1'b0);
    @(negedge core_clk);
    chk(32'(sleeping), 32'h0000_0000);
    rd(4'h4, 32'h0000_0008);
    clockedIntPending <= 1'b0;
    $display("noop done");
  endtask
  task automatic t_sleep_int;
    core.issue(1'b1, 1'b1);
    @(negedge core_clk);
    chk({ioHold, sleeping, mainOscEnable}, 32'h0000_0006);
    chk(coreCtl.prefetchAddr, coreReq.pc + 21'h2);
    rd(4'h4, 32'h0000_0010);
    wakeFlags <= 13'h0002;
    wakeEnables <= 13'h0001;
    repeat (4) @(negedge core_clk);
    chk(32'(sleeping), 32'h0000_0001);
    @(posedge core_clk);
    wakeFlags <= 13'h0001;
    waitPulse;
    chk(pulses(), 32'h0000_0006);
    wakeFlags <= '0;
    $display("int wake done");
  endtask
  task automatic t_sleep_wdt;
    core.issue(1'b1, 1'b0);
    setTick(1'b1);
    waitPulse;
    chk(pulses(), 32'h0000_0004);
    setTick(1'b0);
    rd(4'h4, 32'h0000_0000);
    $display("wdt wake done");
  endtask
  task automatic t_crystal;
    oscCrystalMode <= 1'b1;
    core.issue(1'b1, 1'b0);
    @(posedge core_clk);
    wakeFlags <= 13'h0001;
    waitPulse;
    chk(32'(n >= 1024 && n <= 1028), 32'h0000_0001);
    chk(pulses(), 32'h0000_0004);
    wakeFlags <= '0;
    oscCrystalMode <= 1'b0;
    $display("crystal done");
  endtask
  task automatic t_mreset;
    core.issue(1'b1, 1'b0);
    @(posedge core_clk);
    masterResetReq <= 1'b1;
    @(posedge core_clk);
    masterResetReq <= 1'b0;
    waitPulse;
    chk(pulses(), 32'h0000_0001);
    $display("ext reset done");
  endtask

  // main sequence after two reset cycles
  initial begin
    repeat (2) @(posedge core_clk);
    arst_n <= 1'b1;
    t_regs;
    t_enable;
    t_expire;
    t_clear;
    t_noop;
    t_sleep_int;
    t_sleep_wdt;
    t_crystal;
    t_mreset;
    give_verdict;
  end
  // hang guard, well above the roughly 1400 cycles needed
  initial begin
    repeat (20000) @(posedge core_clk);
    numErrors++;
    give_verdict;
  end
endmodule
`default_nettype wire
